// [src/itwd_divider.sv]
// fourteen stage divider chain with selectable tap
// assumes stepEn is a one-cycle enable at the chosen input clock rate
module itwd_divider (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // control
    input  wire logic        stepEn,
    input  wire logic        clearEn,
    input  wire logic [2:0]  sel,
    input  wire logic [1:0]  wdSel,
    // taps
    output logic             tickEn,
    output logic             wdTapEn
);
    import itwd_pkg::*;

    logic [ITWD_STAGES-1:0] chain_q;
    logic [ITWD_STAGES-1:0] nextChain;
    logic [ITWD_STAGES-1:0] carry;

    // stage index whose carry marks one full divide period
    function automatic int tapOf(input logic [2:0] s);
        case (s)
            3'h0: tapOf = 0;
            3'h1: tapOf = 1;
            3'h2: tapOf = 2;
            3'h3: tapOf = 3;
            3'h4: tapOf = 4;
            3'h5: tapOf = 7;
            3'h6: tapOf = 10;
            default: tapOf = 13;
        endcase
    endfunction

    // stage index for the watchdog tap, one eighth of the reset delay
    function automatic int wdTapOf(input logic [1:0] s);
        case (s)
            2'h0: wdTapOf = 5;
            2'h1: wdTapOf = 7;
            2'h2: wdTapOf = 10;
            default: wdTapOf = 13;
        endcase
    endfunction

    // a stage falling is its carry out, so a restart waits a whole period
    assign nextChain = chain_q + 14'h0001;
    assign carry = chain_q & ~nextChain;

    // counting chain; restart zeros all stages
    always_ff @(posedge clk) begin
        if (!rst_n || clearEn) begin
            chain_q <= '0;
        end else if (stepEn) begin
            chain_q <= nextChain;
        end
    end

    // tap pulse for interval and watchdog; watchdog counts 8, so tap = total/8
    always_comb begin
        tickEn  = stepEn && !clearEn && carry[tapOf(sel)];
        wdTapEn = stepEn && !clearEn && carry[wdTapOf(wdSel)];
    end
endmodule

// [src/itwd_pkg.sv]
// constants, register map and field layout of the interval timer with watchdog
// assumes an apb slave at 32-bit words, one clock at 50 mhz
//
// How it works
// - fourteen stage divider, sub or system clock
// - tick feeds prescaler, sub clock, interrupt
// - tick synced, forced low in sleep
// - aux register holds mask and bypass bits
// - timer runs after power-on with no setup
// - control write with restart bit restarts timer
// - write without restart bit only updates interval
// - restart ignored while watchdog locked
// - interval code picks divide ratio two..16384
// - managed sub clock is input divided by 16
// - three bit watchdog counter, overflow resets system
// - reading clear register zeroes watchdog counter
// - unlocked mode switchable, locked mode sticky
// - lock bit zero enables, locks, ignores stop
// - stop bit one stops, zero runs watchdog
// - watchdog delay divider 512..131072 by code
// - mask one disables irq; source one selects sub
package itwd_pkg;

    // ****************************************
    // register indices, one aligned word each
    // ****************************************
    localparam int ITWD_IDX_INTERVAL = 8;
    localparam int ITWD_IDX_AUX      = 9;
    localparam int ITWD_IDX_WDCTRL   = 10;
    localparam int ITWD_IDX_WDCLEAR  = 11;
    localparam int ITWD_IDX_STATUS   = 12;
    localparam int ITWD_IDX_MODE     = 13;

    // ****************************************
    // register byte addresses, four times the index
    // ****************************************
    localparam logic [11:0] ITWD_ADDR_INTERVAL = 12'(ITWD_IDX_INTERVAL * 4);
    localparam logic [11:0] ITWD_ADDR_AUX      = 12'(ITWD_IDX_AUX * 4);
    localparam logic [11:0] ITWD_ADDR_WDCTRL   = 12'(ITWD_IDX_WDCTRL * 4);
    localparam logic [11:0] ITWD_ADDR_WDCLEAR  = 12'(ITWD_IDX_WDCLEAR * 4);
    localparam logic [11:0] ITWD_ADDR_STATUS   = 12'(ITWD_IDX_STATUS * 4);
    localparam logic [11:0] ITWD_ADDR_MODE     = 12'(ITWD_IDX_MODE * 4);

    // ****************************************
    // field positions
    // ****************************************
    localparam int ITWD_RESTART_BIT = 3;
    localparam int ITWD_BYPASS_BIT  = 2;
    localparam int ITWD_SOURCE_BIT  = 1;
    localparam int ITWD_MASK_BIT    = 0;
    localparam int ITWD_LOCK_BIT    = 3;
    localparam int ITWD_STOP_BIT    = 2;

    // ****************************************
    // reset values and sizes
    // ****************************************
    localparam logic [3:0] ITWD_INTERVAL_RST = 4'hf;
    localparam logic [2:0] ITWD_AUX_RST      = 3'h7;
    localparam logic [3:0] ITWD_WDCTRL_RST   = 4'hc;
    localparam int         ITWD_STAGES       = 14;
    localparam int         ITWD_SUBDIV       = 16;
    localparam logic [3:0] ITWD_SUBDIV_LAST  = 4'(ITWD_SUBDIV - 1);
    localparam logic [2:0] ITWD_WDCNT_LAST   = 3'h7;

endpackage

// [src/itwd_top.sv]
// interval timer with watchdog, apb register slave
// assumes a 32-bit apb master; sub clock and sleep are synchronous inputs
//
// Added by the designer: the APB register port.
module itwd_top (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // clock sources
    input  wire logic        subClockIn,
    input  wire logic        sleepOscStop,
    // timer outputs
    output logic             tickOutput,
    output logic             subClockOut,
    output logic             prescalerEn,
    output logic             tickIrq,
    // watchdog
    output logic             watchdogReset
);
    import itwd_pkg::*;

    // ****************************************
    // registers and state
    // ****************************************
    logic [3:0] interval_q;
    logic [2:0] aux_q;
    logic [3:0] wdCtrl_q;
    logic [2:0] wdCnt_q;
    logic [3:0] mgrDiv_q;
    logic       subPrev_q;
    logic       managed_q;
    logic       restart_q;
    logic       tickPrev_q;
    logic       tickFlag_q;

    logic       setupRd;
    logic       setupWr;
    logic       subEdge;
    logic       subStep;
    logic       stepEn;
    logic       tickEn;
    logic       wdTapEn;
    logic       wdLocked;
    logic       wdRun;
    logic       hit;

    // ****************************************
    // apb decode
    // ****************************************
    always_comb begin
        setupWr = psel && penable && pwrite;
        setupRd = psel && penable && !pwrite;
        case (paddr)
            ITWD_ADDR_INTERVAL, ITWD_ADDR_AUX, ITWD_ADDR_WDCTRL,
            ITWD_ADDR_WDCLEAR, ITWD_ADDR_STATUS, ITWD_ADDR_MODE: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // single-cycle access phase with registered answer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata  <= 32'h0;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    ITWD_ADDR_INTERVAL: prdata <= {28'h0, interval_q};
                    ITWD_ADDR_AUX:      prdata <= {29'h0, aux_q};
                    ITWD_ADDR_WDCTRL:   prdata <= {28'h0, wdCtrl_q};
                    ITWD_ADDR_STATUS:   prdata <= {27'h0, tickFlag_q, 1'b0, wdCnt_q};
                    ITWD_ADDR_MODE:     prdata <= {31'h0, managed_q};
                    default:            prdata <= 32'h0;
                endcase
            end
        end
    end

    wire accWr = setupWr && pready;
    wire accRd = setupRd && pready;

    // ****************************************
    // control registers
    // ****************************************
    // interval control, resets to all ones; timer running from reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            interval_q <= ITWD_INTERVAL_RST;
        end else if (accWr && paddr == ITWD_ADDR_INTERVAL) begin
            interval_q <= pwdata[3:0];
        end
    end

    // restart request, blocked while watchdog locked
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            restart_q <= 1'b0;
        end else begin
            restart_q <= accWr && paddr == ITWD_ADDR_INTERVAL
                         && pwdata[ITWD_RESTART_BIT] && !wdLocked;
        end
    end

    // aux register: bypass, source select, irq mask
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aux_q <= ITWD_AUX_RST;
        end else if (accWr && paddr == ITWD_ADDR_AUX) begin
            aux_q <= pwdata[2:0];
        end
    end

    // sub clock mode: one when sub clock comes from the clock manager
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            managed_q <= 1'b0;
        end else if (accWr && paddr == ITWD_ADDR_MODE) begin
            managed_q <= pwdata[0];
        end
    end

    // watchdog control; lock bit once cleared stays until reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wdCtrl_q <= ITWD_WDCTRL_RST;
        end else if (accWr && paddr == ITWD_ADDR_WDCTRL) begin
            wdCtrl_q[1:0]           <= pwdata[1:0];
            wdCtrl_q[ITWD_LOCK_BIT] <= wdCtrl_q[ITWD_LOCK_BIT] & pwdata[ITWD_LOCK_BIT];
            if (!wdLocked) begin
                wdCtrl_q[ITWD_STOP_BIT] <= pwdata[ITWD_STOP_BIT];
            end
        end
    end

    assign wdLocked = !wdCtrl_q[ITWD_LOCK_BIT];
    // software must start it; running when locked or not stopped
    assign wdRun = wdLocked || !wdCtrl_q[ITWD_STOP_BIT];

    // ****************************************
    // input clock selection
    // ****************************************
    // sub clock edge detect and optional divide by 16
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            subPrev_q <= 1'b0;
            mgrDiv_q  <= 4'h0;
        end else begin
            subPrev_q <= subClockIn;
            if (subEdge) begin
                mgrDiv_q <= mgrDiv_q + 4'h1;
            end
        end
    end

    assign subEdge = subClockIn && !subPrev_q;
    assign subStep = managed_q ? (subEdge && mgrDiv_q == ITWD_SUBDIV_LAST) : subEdge;
    assign stepEn  = aux_q[ITWD_SOURCE_BIT] ? subStep : 1'b1;

    itwd_divider u_div (
        .clk     (clk),
        .rst_n   (rst_n),
        .stepEn  (stepEn),
        .clearEn (restart_q),
        .sel     (interval_q[2:0]),
        .wdSel   (wdCtrl_q[1:0]),
        .tickEn  (tickEn),
        .wdTapEn (wdTapEn)
    );

    // ****************************************
    // tick outputs
    // ****************************************
    // synchronous tick outputs; tick held low in sleep
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tickOutput  <= 1'b0;
            subClockOut <= 1'b0;
            prescalerEn <= 1'b0;
            tickPrev_q  <= 1'b0;
        end else begin
            tickPrev_q  <= tickEn;
            prescalerEn <= tickEn;
            tickOutput  <= !sleepOscStop && (aux_q[ITWD_BYPASS_BIT] ? tickEn : subStep);
            subClockOut <= aux_q[ITWD_BYPASS_BIT] ? tickEn : subStep;
        end
    end

    // interrupt pulse and sticky status; set wins over read clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tickIrq    <= 1'b0;
            tickFlag_q <= 1'b0;
        end else begin
            tickIrq <= tickEn && !aux_q[ITWD_MASK_BIT];
            if (tickEn) begin
                tickFlag_q <= 1'b1;
            end else if (accRd && paddr == ITWD_ADDR_STATUS) begin
                tickFlag_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // watchdog
    // ****************************************
    // counter cleared by reading clear register, reset pulse on overflow
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wdCnt_q       <= 3'h0;
            watchdogReset <= 1'b0;
        end else begin
            watchdogReset <= 1'b0;
            if (accRd && paddr == ITWD_ADDR_WDCLEAR) begin
                wdCnt_q <= 3'h0;
            end else if (wdRun && wdTapEn) begin
                wdCnt_q <= wdCnt_q + 3'h1;
                if (wdCnt_q == ITWD_WDCNT_LAST) begin
                    watchdogReset <= 1'b1;
                end
            end
        end
    end
endmodule

// [verif/itwd_checker.sv]
// port checker for the interval timer with watchdog
// assumes binding onto itwd_top, one clock, sync active-low reset
// ********************
// checker module
// ********************
module itwd_checker (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // apb slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // clock sources
    input wire logic        subClockIn,
    input wire logic        sleepOscStop,
    // timer and watchdog outputs
    input wire logic        tickOutput,
    input wire logic        subClockOut,
    input wire logic        prescalerEn,
    input wire logic        tickIrq,
    input wire logic        watchdogReset
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // bus answers and quiet outputs
    setup_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer one cycle after setup");
    ready_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
        else $error("answer without setup");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error outside access");
    err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    reset_quiet_a: assert property ($past(rst_n) == 1'b0 |-> !(pready || tickIrq))
        else $error("output high after reset");
    // timer and watchdog pulses
    sleep_low_a: assert property (sleepOscStop && $past(sleepOscStop) |-> !tickOutput)
        else $error("tick output runs in sleep");
    sleep_gate_a: assert property (tickOutput |-> subClockOut)
        else $error("tick output without sub clock out");
    irq_cause_a: assert property (tickIrq |-> prescalerEn)
        else $error("irq without tick");
    tick_pulse_a: assert property (prescalerEn |=> !prescalerEn)
        else $error("tick wider than one cycle");
    wd_pulse_a: assert property (watchdogReset |=> !watchdogReset)
        else $error("watchdog reset wider than one cycle");
    cover property (tickIrq);
    cover property (watchdogReset);
    cover property (pslverr);
endmodule

bind itwd_top itwd_checker u_itwd_checker (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .subClockIn, .sleepOscStop, .tickOutput,
    .subClockOut, .prescalerEn, .tickIrq, .watchdogReset);

// [verif/itwd_top_tb.sv]
// self-checking bench for the interval timer with watchdog
// assumes itwd_top with apb slave and the itwd_pkg register map
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module itwd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import itwd_pkg::*;
    // ********************
    // signals and design
    // ********************
    logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, err, subClockIn = 0, sleepOscStop = 0;
    logic        tickOutput, subClockOut, prescalerEn, tickIrq, watchdogReset;
    int          n_errors = 0, cmp_count = 0, n, nT, nI, nP, nS, nWd = 0;
    int          ratio[8] = '{2, 4, 8, 16, 32, 256, 2048, 16384};
    itwd_top u_itwd_top (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .subClockIn, .sleepOscStop, .tickOutput, .subClockOut,
        .prescalerEn, .tickIrq, .watchdogReset);
    always #10 clk = ~clk;
    // watchdog reset pulses seen
    always @(posedge clk) if (watchdogReset === 1'b1) nWd++;
    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one apb transfer, held until pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge clk); penable <= 1'b1;
        i = 0;
        do begin @(posedge clk); i++; end while (pready !== 1'b1 && i < 50);
        rd = prdata; err = pslverr;
        if (i >= 50) begin n_errors++; print_verdict(); end
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
    endtask
    // count pulses over a window, optionally toggling the sub clock
    task count(input int cyc, input logic tog);
        nT = 0; nI = 0; nP = 0; nS = 0;
        repeat (cyc) begin
            @(posedge clk);
            if (tog) subClockIn <= ~subClockIn;
            nT += (tickOutput === 1'b1); nI += (tickIrq === 1'b1); nP += (prescalerEn === 1'b1);
            nS += (subClockOut === 1'b1);
        end
    endtask
    task waitPre(output int c);
        c = 0;
        do begin @(posedge clk); c++; end while (prescalerEn !== 1'b1 && c < 20000);
        if (c >= 20000) begin n_errors++; print_verdict(); end
    endtask
    // write interval control just after a tick, cycles to next tick
    task gap(input logic [31:0] v);
        waitPre(n); @(posedge clk); apb(1, ITWD_ADDR_INTERVAL, v); waitPre(n);
    endtask
    // ********************
    // main sequence
    // ********************
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(0, ITWD_ADDR_INTERVAL, 0); `CHK(rd, 32'h0000000f)
        apb(0, ITWD_ADDR_AUX, 0); `CHK(rd, 32'h00000007)
        apb(0, ITWD_ADDR_WDCTRL, 0); `CHK(rd, 32'h0000000c)
        apb(0, 12'h03c, 0); `CHK(err, 1'b1)
        apb(1, ITWD_ADDR_INTERVAL, 0); count(40, 0); `CHK(nP, 0)
        count(40, 1); `CHK(nP >= 9 && nP <= 11, 1'b1)
        apb(1, ITWD_ADDR_AUX, 32'h4); count(40, 0); `CHK(nP, 20)
        `CHK(nI, 20)
        `CHK(nT, 20)
        apb(1, ITWD_ADDR_AUX, 32'h5); count(40, 0); `CHK(nI, 0)
        sleepOscStop <= 1'b1; @(posedge clk); count(40, 0); `CHK(nT, 0)
        `CHK(nP, 20)
        sleepOscStop <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            apb(1, ITWD_ADDR_INTERVAL, 32'(k)); waitPre(n); waitPre(n);
            `CHK(n, ratio[k])
        end
        apb(1, ITWD_ADDR_INTERVAL, 32'h3); gap(32'hb); `CHK(n >= 15 && n <= 20, 1'b1)
        apb(1, ITWD_ADDR_WDCTRL, 32'h0);
        apb(1, ITWD_ADDR_WDCTRL, 32'hc); apb(0, ITWD_ADDR_WDCTRL, 0); `CHK(rd, 32'h0)
        gap(32'hb); `CHK(n < 14, 1'b1)
        repeat (20) begin repeat (30) @(posedge clk); apb(0, ITWD_ADDR_WDCLEAR, 0); end
        `CHK(nWd, 0)
        n = 0;
        while (watchdogReset !== 1'b1 && n < 2000) begin @(posedge clk); n++; end
        `CHK(n >= 440 && n <= 520, 1'b1)
        rst_n <= 1'b0; repeat (2) @(posedge clk); rst_n <= 1'b1; nWd = 0; @(posedge clk);
        apb(0, ITWD_ADDR_WDCTRL, 0); `CHK(rd, 32'h0000000c)
        apb(1, ITWD_ADDR_AUX, 32'h4); repeat (700) @(posedge clk); `CHK(nWd, 0)
        // unlocked watchdog runs with stop cleared and halts when stop is set again
        apb(1, ITWD_ADDR_WDCTRL, 32'h8); repeat (200) @(posedge clk);
        apb(0, ITWD_ADDR_STATUS, 0); `CHK(rd >= 32'h3 && rd <= 32'h4, 1'b1)
        apb(1, ITWD_ADDR_WDCTRL, 32'hc);
        apb(0, ITWD_ADDR_STATUS, 0);
        n = int'(rd);
        repeat (200) @(posedge clk);
        apb(0, ITWD_ADDR_STATUS, 0); `CHK(rd, 32'(n))
        apb(0, ITWD_ADDR_WDCLEAR, 0); `CHK(rd, 32'h0)
        apb(0, ITWD_ADDR_STATUS, 0); `CHK(rd, 32'h0)
        // managed sub clock divides edges by 16; bypass cleared passes sub clock steps
        apb(1, ITWD_ADDR_INTERVAL, 0);
        apb(1, ITWD_ADDR_MODE, 32'h1);
        apb(1, ITWD_ADDR_AUX, 32'h2);
        count(320, 1); `CHK(nS >= 9 && nS <= 11, 1'b1)
        `CHK(nT >= 9 && nT <= 11, 1'b1)
        `CHK(nP >= 4 && nP <= 6, 1'b1)
        `CHK(nI, nP)
        repeat (5) @(posedge clk);
        apb(0, ITWD_ADDR_STATUS, 0); `CHK(rd, 32'h10)
        apb(0, ITWD_ADDR_STATUS, 0); `CHK(rd, 32'h0)
        print_verdict();
    end
endmodule
